// [pkg/flash_regs_consts.svh]
/*
  Offsets, field positions, reset values and code tables for the flash
  timer and status register pair. Assumes inclusion by bare name.
*/
`ifndef FLASH_REGS_CONSTS_SVH
`define FLASH_REGS_CONSTS_SVH

`define ADDR_TIMER_CTRL 8'h03
`define ADDR_STATUS_CTRL 8'h04

`define TIMER_CTRL_RESET 8'hC1
`define STATUS_CTRL_RESET 8'h00

`define STIM_MSB 7
`define STIM_LSB 5
`define FAULT_BIT 4
`define RANGE_BIT 3
`define TRIG_BIT 2
`define STROBE_BIT 1
`define BLANK_BIT 0
`define PG_BIT 7
`define TEMP_MSB 6
`define TEMP_LSB 5
`define VALLEY_LIMIT_SEL_BIT 4
`define IND_MSB 3
`define IND_LSB 0

`define CLK_KHZ 25000
`define TICKS_PER_100US 2500
`define TIMER_W 16

`define TEMP_SHUTDOWN 2'h3

`endif

// [pkg/flash_regs_pkg.sv]
/*
  Types for the flash timer and status registers. No assumptions.
*/
package flash_regs_pkg;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_DC_LIGHT = 2'b01,
    MODE_FLASH = 2'b10,
    MODE_VOLTAGE = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    CUR_1250 = 2'b00,
    CUR_1750 = 2'b01,
    CUR_250 = 2'b10,
    CUR_500 = 2'b11
  } valley_limit_t;
endpackage

// [hdl/sticky_flag.sv]
/*
  One clear-on-read event flag. Assumes read_done_in is a one-cycle
  pulse marking a completed read of the register holding the flag.
*/
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Event and clear
  input wire logic event_in,
  input wire logic read_done_in,
  // Flag
  output logic flag_out
);
  // Set wins over the read clear so no event is lost
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (event_in) begin
      flag_out <= 1'b1;
    end else if (read_done_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule // sticky_flag

// [hdl/safety_timer.sv]
/*
  LED safety timer in 100 us ticks. Assumes start_in is a one-cycle
  pulse and abort_in ends a running strobe.
*/
`include "flash_regs_consts.svh"
`timescale 1ns/1ps
module safety_timer (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [2:0] safety_time_sel_in,
  input wire logic timer_range_sel_in,
  // Status
  output logic running_out,
  output logic expired_out
);
  logic [`TIMER_W-1:0] limit;
  logic [`TIMER_W-1:0] ticks_q;
  logic [11:0] pre_q;

  // Limits in 100 us units, rounded down
  always_comb begin
    limit = 16'h0000;
    unique case ({timer_range_sel_in, safety_time_sel_in})
      4'h0: limit = 16'h02AA;
      4'h1: limit = 16'h03FE;
      4'h2: limit = 16'h0553;
      4'h3: limit = 16'h06A8;
      4'h4: limit = 16'h07FD;
      4'h5: limit = 16'h0D50;
      4'h6: limit = 16'h16A1;
      4'h7: limit = 16'h2148;
      4'h8: limit = 16'h0035;
      4'h9: limit = 16'h006B;
      4'hA: limit = 16'h00A0;
      4'hB: limit = 16'h00D5;
      4'hC: limit = 16'h010A;
      4'hD: limit = 16'h0140;
      4'hE: limit = 16'h0175;
      4'hF: limit = 16'h081D;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running_out <= 1'b0;
      expired_out <= 1'b0;
      ticks_q <= 16'h0000;
      pre_q <= 12'h000;
    end else begin
      expired_out <= 1'b0;
      if (start_in) begin
        running_out <= 1'b1;
        ticks_q <= 16'h0000;
        pre_q <= 12'h000;
      end else if (abort_in) begin
        running_out <= 1'b0;
      end else if (running_out) begin
        if (pre_q == 12'(`TICKS_PER_100US - 1)) begin
          pre_q <= 12'h000;
          if (ticks_q + 16'h0001 >= limit) begin
            running_out <= 1'b0;
            expired_out <= 1'b1;
          end
          ticks_q <= ticks_q + 16'h0001;
        end else begin
          pre_q <= pre_q + 12'h001;
        end
      end
    end
  end
endmodule // safety_timer

// [hdl/flash_timer_status_regs.sv]
/*
  Two control and status registers of the flash driver: safety timer,
  strobe, blanking, power good routing, temperature, current limit and
  indicator. Assumes a serial front end that delivers one-cycle write
  and read-done strobes with an 8-bit address, and analog status pins
  already synchronous to mclk_in.
*/
`include "flash_regs_consts.svh"
`timescale 1ns/1ps
module flash_timer_status_regs (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Register access from the serial front end
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_done_in,
  // Mode from the mode register
  input wire logic [1:0] op_mode_in,
  // Pins and analog status
  input wire logic strobe_pin_in,
  input wire logic blank_pin_in,
  input wire logic high_current_pin_in,
  input wire logic dc_light_pin_in,
  input wire logic gpio_value_in,
  input wire logic led_fault_in,
  input wire logic power_good_in,
  input wire logic [1:0] die_temp_in,
  // Read data
  output logic [7:0] rd_data_out,
  // Control outputs
  output logic flash_active_out,
  output logic dc_reduce_out,
  output logic gpio_pin_out,
  output logic [1:0] valley_limit_out,
  output logic [1:0] privacy_led_pin_out,
  output logic pwm_dim_en_out,
  output logic [2:0] pwm_dim_code_out,
  output logic [1:0] mode_out
);
  logic [2:0] safety_time_sel_q;
  logic timer_range_sel_q;
  logic timer_trigger_type_q;
  logic blank_en_q;
  logic power_good_route_q;
  logic valley_limit_sel_q;
  logic [3:0] indicator_level_q;
  logic left_shutdown_q;
  logic strobe_pin_q;
  logic timeout_flag_q;
  logic temp_trip_q;
  logic wr_timer;
  logic wr_status;
  logic rd_timer;
  logic rd_status;
  logic sw_start;
  logic pin_start;
  logic timer_start;
  logic timer_abort;
  logic running;
  logic expired;
  logic led_fault_flag;
  logic blank_flag;
  logic flash_mode;
  logic [7:0] rd_data_d;

  assign wr_timer = wr_en_in && (addr_in == `ADDR_TIMER_CTRL);
  assign wr_status = wr_en_in && (addr_in == `ADDR_STATUS_CTRL);
  assign rd_timer = rd_done_in && (addr_in == `ADDR_TIMER_CTRL);
  assign rd_status = rd_done_in && (addr_in == `ADDR_STATUS_CTRL);
  assign flash_mode =
    (op_mode_in == flash_regs_pkg::MODE_FLASH);

  // Writable fields of the timer register
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      safety_time_sel_q <= 3'h6;
      timer_range_sel_q <= 1'b0;
      timer_trigger_type_q <= 1'b0;
      blank_en_q <= 1'b1;
    end else if (wr_timer) begin
      safety_time_sel_q <= wr_data_in[`STIM_MSB:`STIM_LSB];
      timer_range_sel_q <= wr_data_in[`RANGE_BIT];
      timer_trigger_type_q <= wr_data_in[`TRIG_BIT];
      blank_en_q <= wr_data_in[`BLANK_BIT];
    end
  end

  // Writable fields of the status register
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_good_route_q <= 1'b0;
      indicator_level_q <= 4'h0;
    end else if (wr_status) begin
      power_good_route_q <= wr_data_in[`PG_BIT];
      indicator_level_q <= wr_data_in[`IND_MSB:`IND_LSB];
    end
  end

  // Limit select only lands while still in the initial shutdown
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valley_limit_sel_q <= 1'b0;
      left_shutdown_q <= 1'b0;
    end else begin
      if (op_mode_in != flash_regs_pkg::MODE_SHUTDOWN) begin
        left_shutdown_q <= 1'b1;
      end
      if (wr_status && !left_shutdown_q) begin
        valley_limit_sel_q <= wr_data_in[`VALLEY_LIMIT_SEL_BIT];
      end
    end
  end

  // Strobe start: software bit, or pin edge/level in flash mode
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_pin_q <= 1'b0;
    end else begin
      strobe_pin_q <= strobe_pin_in;
    end
  end

  assign sw_start = wr_timer && wr_data_in[`STROBE_BIT];
  // Level mode restarts only when the pin rises from an idle LED
  assign pin_start = flash_mode && strobe_pin_in && (timer_trigger_type_q ?
    !strobe_pin_q : !running && !strobe_pin_q);
  assign timer_start = sw_start || pin_start;
  assign timer_abort = flash_mode && !timer_trigger_type_q &&
    !strobe_pin_in && !sw_start && strobe_pin_q;

  safety_timer u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(timer_start),
    .abort_in(timer_abort),
    .safety_time_sel_in(safety_time_sel_q),
    .timer_range_sel_in(timer_range_sel_q),
    .running_out(running),
    .expired_out(expired)
  );

  // Timeout flag clears only on timer restart, not on read
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timeout_flag_q <= 1'b0;
    end else if (expired) begin
      timeout_flag_q <= 1'b1;
    end else if (timer_start) begin
      timeout_flag_q <= 1'b0;
    end
  end

  sticky_flag u_fault (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .event_in(led_fault_in),
    .read_done_in(rd_timer),
    .flag_out(led_fault_flag)
  );

  sticky_flag u_blank (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .event_in(blank_pin_in),
    .read_done_in(rd_timer),
    .flag_out(blank_flag)
  );

  // Thermal shutdown code latches until a status read
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_trip_q <= 1'b0;
    end else if (die_temp_in == `TEMP_SHUTDOWN) begin
      temp_trip_q <= 1'b1;
    end else if (rd_status) begin
      temp_trip_q <= 1'b0;
    end
  end

  // Read mux; registered so data lines stay glitch free
  always_comb begin
    rd_data_d = 8'h00;
    if (addr_in == `ADDR_TIMER_CTRL) begin
      rd_data_d[`STIM_MSB:`STIM_LSB] = safety_time_sel_q;
      rd_data_d[`FAULT_BIT] = led_fault_flag;
      rd_data_d[`RANGE_BIT] = timeout_flag_q;
      rd_data_d[`TRIG_BIT] = timer_trigger_type_q;
      rd_data_d[`STROBE_BIT] = running;
      rd_data_d[`BLANK_BIT] = blank_flag;
    end else if (addr_in == `ADDR_STATUS_CTRL) begin
      rd_data_d[`PG_BIT] = power_good_in;
      rd_data_d[`TEMP_MSB:`TEMP_LSB] =
        temp_trip_q ? `TEMP_SHUTDOWN : die_temp_in;
      rd_data_d[`VALLEY_LIMIT_SEL_BIT] = valley_limit_sel_q;
      rd_data_d[`IND_MSB:`IND_LSB] = indicator_level_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_data_d;
    end
  end

  // Control outputs, all registered
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_active_out <= 1'b0;
      dc_reduce_out <= 1'b0;
      gpio_pin_out <= 1'b0;
      valley_limit_out <= flash_regs_pkg::CUR_1250;
      privacy_led_pin_out <= 2'h0;
      pwm_dim_en_out <= 1'b0;
      pwm_dim_code_out <= 3'h0;
      mode_out <= flash_regs_pkg::MODE_SHUTDOWN;
    end else begin
      flash_active_out <= running;
      dc_reduce_out <= blank_en_q && blank_pin_in;
      gpio_pin_out <= power_good_route_q ?
        gpio_value_in : power_good_in;
      // Mixed pin levels give the 1250 limit whatever the select bit
      if (high_current_pin_in && blank_pin_in) begin
        valley_limit_out <= valley_limit_sel_q ?
          flash_regs_pkg::CUR_500 : flash_regs_pkg::CUR_250;
      end else begin
        valley_limit_out <= (valley_limit_sel_q && !high_current_pin_in &&
          !blank_pin_in) ? flash_regs_pkg::CUR_1750 :
          flash_regs_pkg::CUR_1250;
      end
      // Codes 0xyy: 00 off, 01 2.6 mA, 10 5.2 mA, 11 7.9 mA (5.2 mA when x is 0)
      if (!indicator_level_q[3]) begin
        privacy_led_pin_out <= (indicator_level_q[1:0] == 2'h3 &&
          !indicator_level_q[2]) ? 2'h2 : indicator_level_q[1:0];
      end else begin
        privacy_led_pin_out <= 2'h0;
      end
      pwm_dim_en_out <= indicator_level_q[3] && !dc_light_pin_in &&
        (op_mode_in == flash_regs_pkg::MODE_DC_LIGHT);
      pwm_dim_code_out <= indicator_level_q[2:0];
      mode_out <= op_mode_in;
    end
  end
endmodule // flash_timer_status_regs

// [sim/flash_regs_assertions.sv]
/* Port checker for the flash register pair.
   Assumes one clock and the async active-low reset of the block. */
`timescale 1ns/1ps
module flash_regs_checker (
  input logic mclk_in, rst_n_in, wr_en_in, rd_done_in,
  input logic blank_pin_in, high_current_pin_in, dc_light_pin_in,
  input logic gpio_value_in, power_good_in, led_fault_in,
  input logic [7:0] addr_in, wr_data_in, rd_data_out,
  input logic flash_active_out, dc_reduce_out, gpio_pin_out,
  input logic pwm_dim_en_out,
  input logic [1:0] valley_limit_out, mode_out
);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence strobe_wr;
    wr_en_in && addr_in == 8'h03 && wr_data_in[1];
  endsequence
  sequence fault_read;
    rd_done_in && addr_in == 8'h03 && !led_fault_in;
  endsequence
  sequence still_quiet;
    addr_in == 8'h03 && !led_fault_in;
  endsequence
  AST_DC_REDUCE: assert property (!blank_pin_in |=> !dc_reduce_out)
    else $error("reduce without blank pin");
  AST_GPIO_ROUTE: assert property (
    $past(rst_n_in) && $past(gpio_value_in) == $past(power_good_in)
    |-> gpio_pin_out == $past(power_good_in))
    else $error("gpio pin wrong");
  AST_PWM_MODE: assert property (
    pwm_dim_en_out |-> mode_out == 2'h1 && !$past(dc_light_pin_in))
    else $error("pwm outside dc light");
  AST_VALLEY_HI: assert property ($past(rst_n_in) |->
    valley_limit_out[1] == $past(high_current_pin_in && blank_pin_in))
    else $error("valley range wrong");
  AST_VALLEY_MIXED: assert property ($past(rst_n_in) &&
    $past(high_current_pin_in ^ blank_pin_in) |-> valley_limit_out == 2'h0)
    else $error("mixed pins not 1250");
  AST_FLASH_START: assert property (
    strobe_wr |-> ##[1:2] flash_active_out)
    else $error("strobe did not start");
  AST_FAULT_CLEAR: assert property (
    fault_read ##1 still_quiet |=> !rd_data_out[4])
    else $error("fault flag not cleared");
  AST_FAULT_HOLD: assert property (
    rd_data_out[4] && !$past(rd_done_in) && $past(addr_in) == 8'h03
    && addr_in == 8'h03 |=> rd_data_out[4])
    else $error("fault flag lost");
  AST_PG_READ: assert property (
    $past(rst_n_in) && $past(addr_in) == 8'h04
    |-> rd_data_out[7] == $past(power_good_in))
    else $error("power good read wrong");
endmodule // flash_regs_checker

bind flash_timer_status_regs flash_regs_checker u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
  .rd_done_in(rd_done_in), .blank_pin_in(blank_pin_in),
  .high_current_pin_in(high_current_pin_in),
  .dc_light_pin_in(dc_light_pin_in), .gpio_value_in(gpio_value_in),
  .power_good_in(power_good_in), .led_fault_in(led_fault_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .flash_active_out(flash_active_out), .dc_reduce_out(dc_reduce_out),
  .gpio_pin_out(gpio_pin_out), .pwm_dim_en_out(pwm_dim_en_out),
  .valley_limit_out(valley_limit_out), .mode_out(mode_out));

// [sim/flash_host.sv]
/* Host model: register writes and reads toward the block.
   Assumes a free-running mclk_in and registered read data. */
`timescale 1ns/1ps
module flash_host (
  input wire logic mclk_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] addr_out,
  output logic wr_en_out,
  output logic [7:0] wr_data_out,
  output logic rd_done_out
);
  initial begin
    addr_out = 8'h00;
    wr_en_out = 1'h0;
    wr_data_out = 8'h00;
    rd_done_out = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wr_en_out <= 1'h1;
    wr_data_out <= d;
    @(posedge mclk_in);
    wr_en_out <= 1'h0;
  endtask
  // Data taken before the clear edge, so flags still show
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk_in);
    addr_out <= a;
    @(posedge mclk_in);
    @(posedge mclk_in);
    q = rd_data_in;
    rd_done_out <= 1'h1;
    @(posedge mclk_in);
    rd_done_out <= 1'h0;
  endtask
endmodule // flash_host

// [sim/flash_timer_status_regs_bench.sv]
/* Bench for the flash register pair: status table, then lock, dimming,
   flag and strobe cases. Assumes flash_host as bus master. */
`timescale 1ns/1ps
module flash_timer_status_regs_bench;
  logic mclk_in, rst_n_in, strobe_pin_in, blank_pin_in, led_fault_in;
  logic high_current_pin_in, dc_light_pin_in, gpio_value_in;
  logic power_good_in, wr_en_in, rd_done_in, flash_active_out;
  logic dc_reduce_out, gpio_pin_out, pwm_dim_en_out;
  logic [1:0] op_mode_in, die_temp_in, valley_limit_out, mode_out;
  logic [1:0] privacy_led_pin_out;
  logic [2:0] pwm_dim_code_out;
  logic [7:0] addr_in, wr_data_in, rd_data_out, q;
  int fails, n_tests;
  // Write data, pins hc bl pg gp, then valley gpio privacy reduce
  logic [17:0] rows [7] = '{{8'h00, 4'h2, 6'h08}, {8'h91, 4'h2, 6'h12},
    {8'h12, 4'hA, 6'h0C}, {8'h17, 4'hE, 6'h3F}, {8'h04, 4'hE, 6'h29},
    {8'h06, 4'h6, 6'h0D}, {8'h85, 4'h1, 6'h0A}};
  flash_timer_status_regs u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
    .rd_done_in(rd_done_in), .op_mode_in(op_mode_in),
    .strobe_pin_in(strobe_pin_in), .blank_pin_in(blank_pin_in),
    .high_current_pin_in(high_current_pin_in),
    .dc_light_pin_in(dc_light_pin_in), .gpio_value_in(gpio_value_in),
    .led_fault_in(led_fault_in), .power_good_in(power_good_in),
    .die_temp_in(die_temp_in), .rd_data_out(rd_data_out),
    .flash_active_out(flash_active_out), .dc_reduce_out(dc_reduce_out),
    .gpio_pin_out(gpio_pin_out), .valley_limit_out(valley_limit_out),
    .privacy_led_pin_out(privacy_led_pin_out),
    .pwm_dim_en_out(pwm_dim_en_out), .pwm_dim_code_out(pwm_dim_code_out),
    .mode_out(mode_out));
  flash_host u_host (.mclk_in(mclk_in), .rd_data_in(rd_data_out),
    .addr_out(addr_in), .wr_en_out(wr_en_in), .wr_data_out(wr_data_in),
    .rd_done_out(rd_done_in));
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic chko(string n, logic [2:0] e, logic [2:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [7:0] m,
                     logic [7:0] e);
    u_host.rd(a, q);
    chk8(n, e, q & m);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic end_sim;
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk_in = 1'h0;
    forever #20 mclk_in = ~mclk_in;
  end
  // Run needs under 150 cycles
  initial begin
    cyc(5000);
    fails++;
    end_sim;
  end
  initial begin
    {rst_n_in, strobe_pin_in, blank_pin_in, led_fault_in} = 4'h0;
    {high_current_pin_in, dc_light_pin_in, gpio_value_in} = 3'h0;
    {power_good_in, op_mode_in, die_temp_in} = 5'h00;
    cyc(16);
    rst_n_in <= 1'h1;
    cyc(2);
    rdc("timer reset", 8'h03, 8'hFF, 8'hC0);
    rdc("status reset", 8'h04, 8'hFF, 8'h00);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk_in);
      {high_current_pin_in, blank_pin_in, power_good_in, gpio_value_in}
        <= rows[i][9:6];
      u_host.wr(8'h04, rows[i][17:10]);
      cyc(2);
      chko("valley", {1'h0, rows[i][5:4]},
        {1'h0, valley_limit_out});
      chko("gpio pin", {2'h0, rows[i][3]}, {2'h0, gpio_pin_out});
      chko("privacy", {1'h0, rows[i][2:1]},
        {1'h0, privacy_led_pin_out});
      chko("reduce", {2'h0, rows[i][0]}, {2'h0, dc_reduce_out});
    end
    op_mode_in <= 2'h1;
    u_host.wr(8'h04, 8'h10);
    cyc(2);
    chko("valley lock", 3'h0, {1'h0, valley_limit_out});
    u_host.wr(8'h04, 8'h8F);
    cyc(2);
    chko("pwm code", 3'h7, pwm_dim_code_out);
    chko("pwm on", 3'h1, {2'h0, pwm_dim_en_out});
    dc_light_pin_in <= 1'h1;
    cyc(2);
    chko("pwm dc pin", 3'h0, {2'h0, pwm_dim_en_out});
    {dc_light_pin_in, op_mode_in} <= 3'h2;
    cyc(2);
    chko("pwm flash", 3'h0, {2'h0, pwm_dim_en_out});
    chko("mode", 3'h2, {1'h0, mode_out});
    {power_good_in, die_temp_in} <= 3'h7;
    cyc(2);
    {power_good_in, die_temp_in} <= 3'h5;
    rdc("temp trip", 8'h04, 8'hE0, 8'hE0);
    rdc("temp live", 8'h04, 8'hE0, 8'hA0);
    led_fault_in <= 1'h1;
    @(posedge mclk_in);
    led_fault_in <= 1'h0;
    u_host.wr(8'h03, 8'hC1);
    rdc("flags", 8'h03, 8'hFF, 8'hD1);
    rdc("flags clear", 8'h03, 8'hFF, 8'hC0);
    u_host.wr(8'h03, 8'h0B);
    cyc(2);
    chko("flash on", 3'h1, {2'h0, flash_active_out});
    rdc("strobe read", 8'h03, 8'hFF, 8'h02);
    u_host.wr(8'h03, 8'h08);
    cyc(2);
    chko("flash held", 3'h1, {2'h0, flash_active_out});
    // Blanking now disabled, so the pin must not reduce
    blank_pin_in <= 1'h1;
    cyc(2);
    chko("reduce off", 3'h0, {2'h0, dc_reduce_out});
    blank_pin_in <= 1'h0;
    strobe_pin_in <= 1'h1;
    cyc(3);
    strobe_pin_in <= 1'h0;
    cyc(3);
    chko("level abort", 3'h0, {2'h0, flash_active_out});
    rdc("idle read", 8'h03, 8'h02, 8'h00);
    u_host.wr(8'h03, 8'h0C);
    strobe_pin_in <= 1'h1;
    cyc(3);
    strobe_pin_in <= 1'h0;
    cyc(3);
    chko("edge hold", 3'h1, {2'h0, flash_active_out});
    // Mid-run reset must stop the strobe and restore the timer register
    rst_n_in <= 1'h0;
    cyc(2);
    chko("reset flash", 3'h0, {2'h0, flash_active_out});
    rst_n_in <= 1'h1;
    cyc(2);
    rdc("timer rerun", 8'h03, 8'hFF, 8'hC0);
    rdc("unmapped", 8'h07, 8'hFF, 8'h00);
    end_sim;
  end
endmodule // flash_timer_status_regs_bench
